// ===== test/sbc_spi_checker.sv
/* pin level assertions of the serial control port.
   bound into every sbc_spi_port instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic spi_select_n_i,
    input wire logic serial_data_out_oe_o,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe_o,
    input wire logic system_reset_n_i,
    input wire logic mode_write_o,
    input wire logic system_reset_req_o,
    input wire logic [11:0] mode_control_o,
    input wire logic [11:0] system_configuration_o,
    input wire logic [11:0] bus_transceiver_control_o,
    input wire logic [11:0] startup_special_config_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic oe_q;
    logic [7:0] rel;
    wire logic [47:0] regs = {mode_control_o, system_configuration_o,
        bus_transceiver_control_o, startup_special_config_o};
    // cycles since a flag read released the line
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            oe_q <= 1'b0;
            rel <= 8'h00;
        end
        else
        begin
            oe_q <= irq_out_n_oe_o;
            if (oe_q && !irq_out_n_oe_o && system_reset_n_i)
                rel <= 8'h01;
            else if (rel != 8'h00 && rel < 8'hf0)
                rel <= rel + 8'h01;
            else
                rel <= 8'h00;
        end
    end
    chk_sdo_float: assert property (
        spi_select_n_i [*5] |-> !serial_data_out_oe_o)
        else $error("data output driven while deselected");
    chk_sdo_drive: assert property (
        !spi_select_n_i [*5] |-> serial_data_out_oe_o)
        else $error("data output floats while selected");
    chk_irq_drain: assert property (
        !irq_out_n_o)
        else $error("interrupt line driven high");
    chk_mode_commit: assert property (
        mode_write_o |-> $past(spi_select_n_i, 3))
        else $error("mode write inside a frame");
    chk_regs_commit: assert property (
        !$stable(regs) |-> $past(spi_select_n_i, 2))
        else $error("register changed inside a frame");
    chk_reset_pulse: assert property (
        system_reset_req_o |=> !system_reset_req_o)
        else $error("reset request longer than one cycle");
    chk_flag_sysrst: assert property (
        !system_reset_n_i [*6] |-> !irq_out_n_oe_o)
        else $error("interrupt held during system reset");
    chk_irq_release: assert property (
        rel != 8'h00 |-> !irq_out_n_oe_o)
        else $error("interrupt returned inside release time");
endmodule // sbc_spi_checker
bind sbc_spi_port sbc_spi_checker u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .spi_select_n_i(spi_select_n_i),
    .serial_data_out_oe_o(serial_data_out_oe_o),
    .irq_out_n_o(irq_out_n_o), .irq_out_n_oe_o(irq_out_n_oe_o),
    .system_reset_n_i(system_reset_n_i),
    .mode_write_o(mode_write_o),
    .system_reset_req_o(system_reset_req_o),
    .mode_control_o(mode_control_o),
    .system_configuration_o(system_configuration_o),
    .bus_transceiver_control_o(bus_transceiver_control_o),
    .startup_special_config_o(startup_special_config_o));
`default_nettype wire

// ===== test/spi_host_model.sv
/* host side of the serial control port: frames of any clock count
   at a 160 ns link period. assumes an 8 ns clock_i. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clock_i,
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o
);
    localparam int HALF = 10;
    // idle: deselected, clock parked low
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // one access of n clocks; returned word in rx
    task automatic xfer(input logic [15:0] tx, input int n,
        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clock_i);
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge clock_i);
        for (int i = 0; i < n; i++)
        begin
            sck_o <= 1'b1;
            mosi_o <= tx[4'hf - 4'(i)];
            repeat (HALF) @(posedge clock_i);
            sck_o <= 1'b0;
            rx = {rx[14:0], miso_i};
            repeat (HALF) @(posedge clock_i);
        end
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        repeat (HALF) @(posedge clock_i);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ===== test/tb.sv
/* testbench of the serial control port: host frames, mode and
   event stimulus, self checks. assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_spi_regs.vh"
module tb;
    logic clock_i, rst_n_i, sys_rst_n;
    logic last_sdo = 1'b0;
    logic [2:0] op_mode;
    logic [11:0] ev;
    logic [15:0] rx;
    logic [15:0] bad [3] = '{16'h0008, 16'h0240, 16'h0258};
    wire logic cs_n, sck, mosi, serial_data_out, sdo_oe, irq_oe, mw, rst_req;
    wire logic [11:0] mode_ctl, cfg, phy, spec;
    int bad_count, checks_done, cyc, n_mw, n_rst, k;
    // floating data line reads the inverse of its last level
    wire logic miso = sdo_oe ? serial_data_out : ~last_sdo;
    spi_host_model host (.clock_i(clock_i), .miso_i(miso),
        .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi));
    sbc_spi_port #(.IRQ_READ_TIMEOUT_CYC(32'd200)) DUT (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .spi_select_n_i(cs_n),
        .serial_clock_i(sck), .serial_data_in_i(mosi),
        .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
        .irq_out_n_o(), .irq_out_n_oe_o(irq_oe),
        .system_reset_n_i(sys_rst_n), .op_mode_i(op_mode),
        .status_word_i(12'h5a3), .diagnosis_word_i(12'ha5c),
        .irq_event_i(ev), .mode_control_o(mode_ctl), .mode_write_o(mw),
        .system_configuration_o(cfg), .bus_transceiver_control_o(phy),
        .startup_special_config_o(spec), .system_reset_req_o(rst_req));
    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // pulse counters and run limit
    always @(posedge clock_i)
    begin
        if (sdo_oe)
            last_sdo <= serial_data_out;
        n_mw <= n_mw + int'(mw);
        n_rst <= n_rst + int'(rst_req);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic acc(input logic [15:0] f, input int n = 16);
        host.xfer(f, n, rx);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // register map, refusals and interrupt line in sequence
    initial
    begin
        rst_n_i = 1'b0;
        sys_rst_n = 1'b1;
        op_mode = `MODE_NORMAL;
        ev = 12'h000;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        acc(16'h1000);
        chk("status", 16'h05a3, rx);
        acc(16'h3000);
        chk("diagnosis", 16'h0a5c, rx);
        acc(16'h83c5);
        acc(16'hc6a9);
        acc(16'h9fff);
        chk("cfg_rb", 16'h03c5, rx);
        acc(16'hdfff);
        chk("phy_rb", 16'h06a9, rx);
        chk("cfg", 16'h03c5, {4'h0, cfg});
        chk("phy", 16'h06a9, {4'h0, phy});
        acc(16'h4001);
        acc(16'h5000);
        chk("irq_en_rb", 16'h0001, rx);
        acc(16'h8000, 15);
        acc(16'hc000, 17);
        chk("cfg_keep", 16'h03c5, {4'h0, cfg});
        chk("phy_keep", 16'h06a9, {4'h0, phy});
        chk("irq_set", 16'h0001, {15'h0, irq_oe});
        acc(16'h6001);
        chk("flags", 16'h0001, rx);
        chk("irq_clr", 16'h0000, {15'h0, irq_oe});
        k = n_rst;
        ev <= 12'h001;
        @(posedge clock_i);
        ev <= 12'h000;
        repeat (200) @(posedge clock_i);
        chk("irq_held", 16'h0000, {15'h0, irq_oe});
        repeat (60) @(posedge clock_i);
        chk("irq_again", 16'h0001, {15'h0, irq_oe});
        chk("rd_timeout", 16'(k + 1), 16'(n_rst));
        sys_rst_n <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk("irq_sysrst", 16'h0000, {15'h0, irq_oe});
        sys_rst_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        acc(16'h6001);
        chk("flags_sysrst", 16'h0000, rx);
        k = n_mw;
        acc(16'h0248);
        chk("mode", 16'h0248, {4'h0, mode_ctl});
        chk("mode_wr", 16'(k + 1), 16'(n_mw));
        // refused mode words, the last one from standby
        for (int i = 0; i < 3; i++)
        begin
            k = n_rst;
            op_mode <= (i == 2) ? `MODE_STANDBY : `MODE_NORMAL;
            acc(bad[i]);
            chk("mode_bad", 16'h0248, {4'h0, mode_ctl});
            chk("mode_rst", 16'(k + 1), 16'(n_rst));
        end
        op_mode <= `MODE_STARTUP;
        acc(16'h47e1);
        acc(16'h7000);
        chk("special_rb", 16'h07e1, rx);
        chk("special", 16'h07e1, {4'h0, spec});
        acc(16'h8155);
        acc(16'hb000);
        chk("scratch_rb", 16'h0155, rx);
        chk("cfg_scratch", 16'h03c5, {4'h0, cfg});
        k = n_rst;
        acc(16'hc000, 15);
        chk("miscount_rst", 16'(k + 1), 16'(n_rst));
        // flash mode: scratch 1 takes address 3, mode 1 is refused
        op_mode <= `MODE_FLASH;
        acc(16'hc0f0);
        acc(16'hf000);
        chk("scratch1_rb", 16'h00f0, rx);
        chk("phy_flash", 16'h06a9, {4'h0, phy});
        k = n_rst;
        acc(16'h0248);
        chk("flash_mode_rst", 16'(k + 1), 16'(n_rst));
        chk("flash_mode_keep", 16'h0248, {4'h0, mode_ctl});
        // restart mode: a long frame resets as well
        op_mode <= `MODE_RESTART;
        k = n_rst;
        acc(16'hc000, 17);
        chk("restart_rst", 16'(k + 1), 16'(n_rst));
        end_sim();
    end
endmodule // tb
`default_nettype wire

// ===== verilog/sbc_spi_port.v
/*
 * Serial control port of a system basis chip: 16-bit full duplex
 * frames, mode dependent register map, mode register checks and the
 * open-drain interrupt line with its release and read timers.
 * Assumes the serial pins and the system reset pin are asynchronous
 * to clock_i, and that op_mode_i, the status words and the event
 * pulses come from logic on clock_i.
 */
// Summary of operation
// - exactly 16 clocks per select cycle; else flag failure, drop access
// - miscounted frame in start-up or restart requests a system reset
// - input sampled on falling clock, output changed on rising clock
// - select is active low; data output floats while select is high
// - feedback word shifts out while control bits shift in
// - frame is 4 header bits followed by 12 data bits
// - two address bits, readback select bit, read-only bit
// - read-only frames return data and write no register; a read-only flag read still clears the flags
// - address 0 writes mode control; reads status or diagnosis
// - address 1 writes enables or special config by mode, nothing in sleep; reads feedback
// - address 2 writes configuration or scratch 0 by mode
// - address 3 writes transceiver control or scratch 1 by mode
// - forbidden mode transition requests an immediate system reset
// - undefined mode or period code is ignored and resets the system
// - one mode write both retriggers watchdog and selects the mode
// - interrupt line pulled low while any flag is set
// - reading flags clears them; system reset low clears them too
// - line stays released for the release time after each flag read
// - flags left unread past the read timeout reset the system
// - every writable control bit except mode control reads back through a feedback word
// - bits 15-14 address, bit 13 readback select, bit 12 read-only
`include "sbc_spi_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_port #(
    parameter [31:0] IRQ_READ_TIMEOUT_CYC = `IRQ_READ_TIMEOUT_CYC
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire spi_select_n_i,
    input wire serial_clock_i,
    input wire serial_data_in_i,
    output wire serial_data_out_o,
    output wire serial_data_out_oe_o,
    output wire irq_out_n_o,
    output wire irq_out_n_oe_o,
    input wire system_reset_n_i,
    input wire [2:0] op_mode_i,
    input wire [11:0] status_word_i,
    input wire [11:0] diagnosis_word_i,
    input wire [11:0] irq_event_i,
    output wire [11:0] mode_control_o,
    output wire mode_write_o,
    output wire [11:0] system_configuration_o,
    output wire [11:0] bus_transceiver_control_o,
    output wire [11:0] startup_special_config_o,
    output wire system_reset_req_o
);

    // start-up and restart share a register map
    function is_setup_mode;
        input [2:0] m;
        begin
            is_setup_mode = (m == `MODE_STARTUP) || (m == `MODE_RESTART);
        end
    endfunction

    // watchdog period codes that the mode register accepts
    function period_code_ok;
        input [5:0] c;
        begin
            case (c)
                6'h09, 6'h0c, 6'h12, 6'h14, 6'h1b,
                6'h24, 6'h2d, 6'h33, 6'h35, 6'h36:
                    period_code_ok = 1'b1;
                default:
                    period_code_ok = 1'b0;
            endcase
        end
    endfunction

    // mode transitions the system controller permits
    function transition_ok;
        input [2:0] cur;
        input [2:0] om;
        begin
            case (cur)
                `MODE_STARTUP, `MODE_RESTART:
                    transition_ok = (om == `OM_NORMAL) ||
                        (om == `OM_INIT_FLASH) || (om == `OM_INIT_NORMAL);
                `MODE_NORMAL:
                    transition_ok = (om != `OM_LEAVE_FLASH);
                `MODE_STANDBY:
                    transition_ok = (om == `OM_NORMAL) ||
                        (om == `OM_STANDBY) || (om == `OM_SLEEP) ||
                        (om == `OM_INIT_NORMAL);
                `MODE_FLASH:
                    transition_ok = (om == `OM_LEAVE_FLASH) ||
                        (om == `OM_FLASH);
                default:
                    transition_ok = 1'b0;
            endcase
        end
    endfunction

    // two-flop synchronisers; clock and select add an edge history stage
    reg sck_meta, sck_sync, sck_prev;
    reg cs_meta, cs_sync, cs_prev;
    reg sdi_meta, sdi_sync;
    reg system_reset_n_meta, system_reset_n_sync;

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
            system_reset_n_meta <= 1'b0;
            system_reset_n_sync <= 1'b0;
        end
        else
        begin
            sck_meta <= serial_clock_i;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            cs_meta <= spi_select_n_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            sdi_meta <= serial_data_in_i;
            sdi_sync <= sdi_meta;
            system_reset_n_meta <= system_reset_n_i;
            system_reset_n_sync <= system_reset_n_meta;
        end
    end

    // clock edges seen inside a select-low window; select edges always
    wire active = ~cs_sync;
    wire sck_fall = active & sck_prev & ~sck_sync;
    wire sck_rise = active & ~sck_prev & sck_sync;
    wire cs_fall = cs_prev & ~cs_sync;
    wire cs_rise = ~cs_prev & cs_sync;

    reg [15:0] rx_shift;
    reg [4:0] bit_cnt;
    reg [11:0] tx_shift;
    reg serial_data_out;

    // registers written over the port, plus the interrupt flags
    reg [11:0] mode_control, irq_enable, special_cfg, sys_cfg;
    reg [11:0] phy_ctrl, scratch0, scratch1, irq_flags;

    // header of the frame in flight, completed by the fourth bit
    wire [3:0] live_hdr = {rx_shift[2:0], sdi_sync};

    // feedback word chosen by address and readback select
    reg [11:0] feedback;
    always @*
    begin
        // status or diagnosis at address 0
        // written bits other than mode control read back through feedback words
        case (live_hdr[3:2])
            `ADDR_MODE:
                feedback = live_hdr[1] ? diagnosis_word_i : status_word_i;
            `ADDR_IRQ:
                // enables; with readback select flags, or special feedback during set-up
                if (!live_hdr[1])
                    feedback = irq_enable;
                else if (is_setup_mode(op_mode_i))
                    feedback = special_cfg;
                else
                    feedback = irq_flags;
            `ADDR_CFG:
                feedback = live_hdr[1] ? scratch0 : sys_cfg;
            default:
                feedback = live_hdr[1] ? scratch1 : phy_ctrl;
        endcase
    end

    // shift engine, msb first in both directions
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            tx_shift <= 12'h000;
            serial_data_out <= 1'b0;
        end
        else if (cs_fall)
        begin
            bit_cnt <= 5'h00;
            serial_data_out <= 1'b0;
        end
        else if (sck_fall)
        begin
            rx_shift <= {rx_shift[14:0], sdi_sync};
            if (bit_cnt != `CNT_MAX)
                bit_cnt <= bit_cnt + 5'h01;
            // feedback loaded once the header is in
            if (bit_cnt == `HDR_BITS - 5'h01)
                tx_shift <= feedback;
        end
        // data bits follow the four header bits
        else if (sck_rise && bit_cnt >= `HDR_BITS &&
                 bit_cnt < `FRAME_BITS)
        begin
            serial_data_out <= tx_shift[11];
            tx_shift <= {tx_shift[10:0], 1'b0};
        end
    end

    // output floats while select is high
    assign serial_data_out_o = serial_data_out;
    assign serial_data_out_oe_o = active;

    // end of frame decisions
    // exactly sixteen clocks
    wire frame_ok = cs_rise & (bit_cnt == `FRAME_BITS);
    wire frame_bad = cs_rise & (bit_cnt != `FRAME_BITS);
    wire [1:0] addr = {rx_shift[`ADDR_HI_BIT], rx_shift[`ADDR_LO_BIT]};
    wire readback_select = rx_shift[`RRS_BIT];
    wire ro = rx_shift[`RO_BIT];
    wire [11:0] wdata = rx_shift[11:0];
    wire setup = is_setup_mode(op_mode_i);
    // commit only after a valid frame
    wire do_write = frame_ok & ~ro;
    wire mode_wr = do_write & (addr == `ADDR_MODE);
    wire [2:0] om = wdata[`OM_HI:`OM_LO];
    wire code_bad = (om == 3'h0) | ~period_code_ok(wdata[`NWP_HI:`NWP_LO]);
    wire trans_bad = ~transition_ok(op_mode_i, om);
    wire mode_bad = mode_wr & (code_bad | trans_bad);
    wire spi_fail_set = frame_bad & ~setup & irq_enable[`IRQ_SPI_FAIL_BIT];
    wire flag_read = frame_ok & (addr == `ADDR_IRQ) & readback_select & ~setup;

    reg mode_write, reset_req;
    reg [31:0] timeout_cnt;
    wire timeout_hit = (timeout_cnt == IRQ_READ_TIMEOUT_CYC - 32'd1);

    // register writes and system reset requests
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_control <= `MODE_CTRL_RST;
            irq_enable <= `IRQ_EN_RST;
            special_cfg <= `SPECIAL_RST;
            sys_cfg <= `CFG_RST;
            phy_ctrl <= `PHY_RST;
            scratch0 <= `SCRATCH_RST;
            scratch1 <= `SCRATCH_RST;
            mode_write <= 1'b0;
            reset_req <= 1'b0;
        end
        else
        begin
            // one write retriggers and selects mode
            mode_write <= mode_wr & ~mode_bad;
            reset_req <= mode_bad | (frame_bad & setup) | timeout_hit;
            if (do_write)
            begin
                case (addr)
                    `ADDR_MODE:
                        if (!mode_bad)
                            mode_control <= wdata;
                    `ADDR_IRQ:
                        if (setup)
                            special_cfg <= wdata;
                        else if (op_mode_i != `MODE_SLEEP)
                            irq_enable <= wdata;
                    `ADDR_CFG:
                        if (op_mode_i == `MODE_NORMAL ||
                            op_mode_i == `MODE_STANDBY)
                            sys_cfg <= wdata;
                        else
                            scratch0 <= wdata;
                    default:
                        if (op_mode_i == `MODE_NORMAL ||
                            op_mode_i == `MODE_STANDBY)
                            phy_ctrl <= wdata;
                        else
                            scratch1 <= wdata;
                endcase
            end
        end
    end

    // interrupt flags: a new event wins over the read clear
    reg [11:0] next_flags;
    always @*
    begin
        next_flags = flag_read ? 12'h000 : irq_flags;
        next_flags = next_flags | (irq_event_i & irq_enable);
        if (spi_fail_set)
            next_flags[`IRQ_SPI_FAIL_BIT] = 1'b1;
        // cleared while system reset is low
        if (!system_reset_n_sync)
            next_flags = 12'h000;
    end

    reg [31:0] release_cnt;
    reg irq_low;

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_flags <= 12'h000;
            release_cnt <= 32'd0;
            timeout_cnt <= 32'd0;
            irq_low <= 1'b0;
        end
        else
        begin
            irq_flags <= next_flags;
            if (flag_read)
                release_cnt <= `IRQ_RELEASE_CYC;
            else if (release_cnt != 32'd0)
                release_cnt <= release_cnt - 32'd1;
            // read timeout runs while flags wait
            if (irq_flags == 12'h000 || flag_read || timeout_hit ||
                !system_reset_n_sync)
                timeout_cnt <= 32'd0;
            else
                timeout_cnt <= timeout_cnt + 32'd1;
            // pull low while any flag is set and the release time is over
            irq_low <= (next_flags != 12'h000) &
                ((flag_read ? `IRQ_RELEASE_CYC : release_cnt) <= 32'd1);
        end
    end

    // open-drain interrupt: drive low only when enabled
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe_o = irq_low;

    assign mode_control_o = mode_control;
    assign mode_write_o = mode_write;
    assign system_configuration_o = sys_cfg;
    assign bus_transceiver_control_o = phy_ctrl;
    assign startup_special_config_o = special_cfg;
    assign system_reset_req_o = reset_req;

endmodule // sbc_spi_port

`default_nettype wire

// ===== verilog/sbc_spi_regs.vh
/*
 * Constants of the serial control port: frame layout, register
 * addresses, mode register fields, operating mode codes and times.
 * Assumes a 125 MHz system clock.
 */
`ifndef SBC_SPI_REGS_VH
`define SBC_SPI_REGS_VH

// frame layout, msb first
`define FRAME_BITS 5'h10
`define HDR_BITS 5'h04
`define CNT_MAX 5'h11
`define ADDR_HI_BIT 15
`define ADDR_LO_BIT 14
`define RRS_BIT 13
`define RO_BIT 12
`define DATA_BITS 12

// register addresses
`define ADDR_MODE 2'h0
`define ADDR_IRQ 2'h1
`define ADDR_CFG 2'h2
`define ADDR_PHY 2'h3

// register reset values
`define MODE_CTRL_RST 12'h000
`define IRQ_EN_RST 12'h000
`define SPECIAL_RST 12'h000
`define CFG_RST 12'h000
`define PHY_RST 12'h000
`define SCRATCH_RST 12'h000

// mode register fields
`define NWP_HI 11
`define NWP_LO 6
`define OM_HI 5
`define OM_LO 3

// operating mode requests in the mode register
`define OM_NORMAL 3'h1
`define OM_STANDBY 3'h2
`define OM_INIT_FLASH 3'h3
`define OM_SLEEP 3'h4
`define OM_INIT_NORMAL 3'h5
`define OM_LEAVE_FLASH 3'h6
`define OM_FLASH 3'h7

// present operating mode from the system controller
`define MODE_STARTUP 3'h0
`define MODE_NORMAL 3'h1
`define MODE_STANDBY 3'h2
`define MODE_FLASH 3'h3
`define MODE_SLEEP 3'h4
`define MODE_RESTART 3'h5

// interrupt flag raised by a miscounted frame
`define IRQ_SPI_FAIL_BIT 0

// timing
`define CLK_MHZ 32'd125
`define IRQ_RELEASE_NS 32'd2000
`define IRQ_RELEASE_CYC ((`IRQ_RELEASE_NS * `CLK_MHZ + 32'd999) / 32'd1000)
`define IRQ_READ_TIMEOUT_US 32'd1500
`define IRQ_READ_TIMEOUT_CYC (`IRQ_READ_TIMEOUT_US * `CLK_MHZ)

`endif
